// ### include/pwm_pkg.sv
// Shared constants for the five-channel compare PWM block.
// Assumes a single 100 MHz clock and an Avalon-MM register slave.
package pwm_pkg;
  localparam int NUM_CH = 5;
  localparam int DATA_W = 16;
  localparam int VEC_W = 3;
  // Word offsets (byte address = 4 * index)
  localparam logic [5:0] OFS_PERIOD = 6'h00;
  localparam logic [5:0] OFS_PRESCALE = 6'h01;
  localparam logic [5:0] OFS_FLAGS = 6'h02;
  localparam logic [5:0] OFS_ENABLES = 6'h03;
  localparam logic [5:0] OFS_PORT_OUT = 6'h04;
  localparam logic [5:0] OFS_PIN_DIR = 6'h05;
  localparam logic [5:0] OFS_IRQ_STAT = 6'h06;
  localparam logic [5:0] OFS_CH_BASE = 6'h08;
  localparam logic [5:0] CH_STRIDE = 6'h04;
  localparam logic [1:0] CH_CTRL = 2'h0;
  localparam logic [1:0] CH_ACTIVE = 2'h1;
  localparam logic [1:0] CH_BUFFER = 2'h2;
  localparam logic [1:0] CH_PRIO = 2'h3;
  // Control register fields
  localparam int CTRL_ON_BIT = 15;
  localparam int CTRL_FLT_BIT = 4;
  localparam logic [2:0] MODE_PWM = 3'h6;
  localparam logic [2:0] MODE_PWM_FAULT = 3'h7;
  localparam logic [2:0] PRIO_NONE = 3'h0;
  localparam logic [DATA_W-1:0] RESET_WORD = 16'h0000;
  localparam logic [15:0] RESET_PRESCALE = 16'h0000;
  localparam logic [4:0] RESET_DIR = 5'h1F;
  localparam int FAULT_B_CH = 4;
endpackage

// ### design/prescale_div.sv
// Prescaler: one-cycle tick every (ratio+1) clocks.
// Assumes ratio is static while the time base runs.
`timescale 1ns/1ps
module prescale_div #(
  parameter int W = 16
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] ratio,
  output logic tick
);
  logic [W-1:0] cnt_q;
  wire logic wrap = (cnt_q >= ratio);
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_q <= '0;
      tick <= 1'b0;
    end else begin
      cnt_q <= wrap ? '0 : W'(cnt_q + 1'b1);
      tick <= wrap;
    end
  end
endmodule // prescale_div

// ### design/irq_arbiter.sv
// Priority arbiter: picks pending source by group, subpriority, then lowest number.
// Assumes requests are levels held until software clears the flag.
`timescale 1ns/1ps
module irq_arbiter #(
  parameter int N = 5
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [N-1:0] req,
  input wire logic [N*3-1:0] prio,
  input wire logic [N*2-1:0] sub,
  output logic cpuIrq,
  output logic [2:0] vector,
  output logic [2:0] level
);
  import pwm_pkg::*;
  logic [4:0] best [N+1];
  logic [2:0] idx [N+1];
  logic [N:0] any;
  assign best[0] = 5'h00;
  assign idx[0] = 3'h0;
  assign any[0] = 1'b0;
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_arb
      wire logic [4:0] key = {prio[g*3 +: 3], sub[g*2 +: 2]};
      wire logic live = req[g] && (prio[g*3 +: 3] != PRIO_NONE);
      // Strictly greater keeps the lower number on a tie
      wire logic win = live && (!any[g] || key > best[g]);
      assign best[g+1] = win ? key : best[g];
      assign idx[g+1] = win ? 3'(g) : idx[g];
      assign any[g+1] = any[g] | live;
    end
  endgenerate
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cpuIrq <= 1'b0;
      vector <= 3'h0;
      level <= 3'h0;
    end else begin
      cpuIrq <= any[N];
      vector <= idx[N];
      level <= best[N][4:2];
    end
  end
endmodule // irq_arbiter

// ### design/compare_pwm_channels.sv
// Five compare channels in PWM mode with double-buffered duty, fault shutdown and interrupts.
// Assumes Avalon-MM master, synchronous pins, one 100 MHz clock.
`timescale 1ns/1ps
module compare_pwm_channels #(
  parameter int N = pwm_pkg::NUM_CH,
  parameter int W = pwm_pkg::DATA_W
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic fault_input_a_n,
  input wire logic fault_input_b_n,
  output logic [pwm_pkg::NUM_CH-1:0] compare_output_pin,
  output logic [pwm_pkg::NUM_CH-1:0] compare_output_pin_oe,
  output logic [pwm_pkg::NUM_CH-1:0] channelIrq,
  output logic cpuIrq,
  output logic [2:0] irqVector,
  output logic [2:0] irqLevel
);
  import pwm_pkg::*;

  logic [W-1:0] periodReg_q;
  logic [15:0] prescale_q;
  logic [W-1:0] timer_q;
  logic [N-1:0] flag_q;
  logic [N-1:0] enable_q;
  logic [N-1:0] portOut_q;
  logic [N-1:0] pinDir_q;
  logic [15:0] ctrl_q [N];
  logic [W-1:0] dutyActive_q [N];
  logic [W-1:0] dutyBuffer_q [N];
  logic [2:0] prio_q [N];
  logic [1:0] sub_q [N];
  logic [N-1:0] level_q;
  logic [N-1:0] fault_q;
  logic [N-1:0] pwmOut;
  logic [N-1:0] pinNext;
  logic [N-1:0] oeNext;
  logic [31:0] chWord [N];
  logic [N-1:0] faultIn;
  logic [N-1:0] setFlag;
  logic [N*3-1:0] prioFlat;
  logic [N*2-1:0] subFlat;
  logic tick;
  logic ackPend_q;
  logic [31:0] rdata;

  wire logic [5:0] word = avs_address[7:2];
  wire logic access = (avs_read || avs_write) && avs_waitrequest;
  wire logic acceptNow = access && !ackPend_q;
  // Writes land at the edge that completes the transfer
  wire logic wrEn = avs_write && !avs_waitrequest;
  wire logic periodMatch = tick && (timer_q == periodReg_q);
  wire logic inChan = (word >= OFS_CH_BASE) && (word < 6'(OFS_CH_BASE + N * CH_STRIDE));
  wire logic [5:0] chOfs = 6'(word - OFS_CH_BASE);
  wire logic [2:0] chSel = chOfs[4:2];
  wire logic [1:0] chReg = chOfs[1:0];
  wire logic [15:0] wr16 = avs_writedata[15:0];

  function automatic logic chWrite(input logic [2:0] c, input logic [1:0] r, input logic [2:0] sel,
                                   input logic [1:0] rg, input logic en, input logic hit);
    chWrite = en && hit && (sel == c) && (rg == r);
  endfunction

  function automatic logic isPwm(input logic [2:0] m);
    isPwm = (m == MODE_PWM) || (m == MODE_PWM_FAULT);
  endfunction

  prescale_div #(.W(16)) u_div (
    .clk(clk),
    .sys_rst(sys_rst),
    .ratio(prescale_q),
    .tick(tick)
  );

  // Shared time base
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      timer_q <= RESET_WORD;
    end else if (tick) begin
      timer_q <= periodMatch ? RESET_WORD : W'(timer_q + 1'b1);
    end
  end

  // Global registers
  wire logic wrPeriod = wrEn && (word == OFS_PERIOD) && avs_byteenable[0];
  wire logic wrPresc = wrEn && (word == OFS_PRESCALE) && avs_byteenable[0];
  wire logic wrFlags = wrEn && (word == OFS_FLAGS) && avs_byteenable[0];
  wire logic wrEnab = wrEn && (word == OFS_ENABLES) && avs_byteenable[0];
  wire logic wrPort = wrEn && (word == OFS_PORT_OUT) && avs_byteenable[0];
  wire logic wrDir = wrEn && (word == OFS_PIN_DIR) && avs_byteenable[0];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      periodReg_q <= RESET_WORD;
      prescale_q <= RESET_PRESCALE;
    end else begin
      if (wrPeriod) periodReg_q <= wr16;
      if (wrPresc) prescale_q <= wr16;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      enable_q <= '0;
    end else if (wrEnab) begin
      enable_q <= avs_writedata[N-1:0];
    end
  end

  // Port bits only reach a pin while its channel is off
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      portOut_q <= '0;
      pinDir_q <= RESET_DIR;
    end else begin
      if (wrPort) portOut_q <= avs_writedata[N-1:0];
      if (wrDir) pinDir_q <= avs_writedata[N-1:0];
    end
  end

  // Flags: write one to clear, a new event wins over the clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flag_q <= '0;
    end else begin
      flag_q <= (flag_q & ~(wrFlags ? avs_writedata[N-1:0] : '0)) | setFlag;
    end
  end

  genvar c;
  generate
    for (c = 0; c < N; c++) begin : g_ch
      wire logic [2:0] cid = 3'(c);
      wire logic wrCtrl = chWrite(cid, CH_CTRL, chSel, chReg, wrEn, inChan);
      wire logic wrAct = chWrite(cid, CH_ACTIVE, chSel, chReg, wrEn, inChan);
      wire logic wrBuf = chWrite(cid, CH_BUFFER, chSel, chReg, wrEn, inChan);
      wire logic wrPri = chWrite(cid, CH_PRIO, chSel, chReg, wrEn, inChan);
      wire logic on = ctrl_q[c][CTRL_ON_BIT];
      wire logic running = on && isPwm(ctrl_q[c][2:0]);
      wire logic faultMode = ctrl_q[c][2:0] == MODE_PWM_FAULT;
      wire logic newFault = running && faultMode && !faultIn[c] && !fault_q[c];
      // Active duty is read-only while in a PWM mode
      wire logic actWritable = !isPwm(ctrl_q[c][2:0]);

      assign faultIn[c] = (c == FAULT_B_CH) ? fault_input_b_n : fault_input_a_n;
      // High below the active duty; zero stays low, above the period stays high
      assign pwmOut[c] = running && (timer_q < dutyActive_q[c]);
      // Shutdown releases the pin while the latch or, in fault mode, the live fault holds
      wire logic shutDown = fault_q[c] || (faultMode && !faultIn[c]);
      assign pinNext[c] = on ? pwmOut[c] : portOut_q[c];
      assign oeNext[c] = on ? !shutDown : !pinDir_q[c];
      assign setFlag[c] = newFault || (running && periodMatch);
      assign prioFlat[c*3 +: 3] = prio_q[c];
      assign subFlat[c*2 +: 2] = sub_q[c];
      wire logic [15:0] ctrlView = {ctrl_q[c][15:5], fault_q[c], ctrl_q[c][3:0]};
      assign chWord[c] = (chReg == CH_CTRL) ? {16'h0000, ctrlView} :
        (chReg == CH_ACTIVE) ? {16'h0000, dutyActive_q[c]} :
        (chReg == CH_BUFFER) ? {16'h0000, dutyBuffer_q[c]} : {27'h0, prio_q[c], sub_q[c]};

      always_ff @(posedge clk) begin
        if (sys_rst) begin
          ctrl_q[c] <= RESET_WORD;
          dutyBuffer_q[c] <= RESET_WORD;
        end else begin
          if (wrCtrl) ctrl_q[c] <= wr16;
          if (wrBuf) dutyBuffer_q[c] <= wr16;
        end
      end

      always_ff @(posedge clk) begin
        if (sys_rst) begin
          dutyActive_q[c] <= RESET_WORD;
        end else if (wrAct && actWritable) begin
          dutyActive_q[c] <= wr16;
        end else if (running && periodMatch) begin
          dutyActive_q[c] <= dutyBuffer_q[c];
        end
      end

      always_ff @(posedge clk) begin
        if (sys_rst) begin
          prio_q[c] <= PRIO_NONE;
          sub_q[c] <= 2'h0;
        end else if (wrPri) begin
          prio_q[c] <= avs_writedata[4:2];
          sub_q[c] <= avs_writedata[1:0];
        end
      end

      // Fault latches; released by a mode rewrite once the pin is high again
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          fault_q[c] <= 1'b0;
        end else if (newFault) begin
          fault_q[c] <= 1'b1;
        end else if (wrCtrl && faultIn[c]) begin
          fault_q[c] <= 1'b0;
        end
      end
    end
  endgenerate

  // Pin ownership and output drive
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      compare_output_pin <= '0;
      compare_output_pin_oe <= '0;
    end else begin
      compare_output_pin <= pinNext;
      compare_output_pin_oe <= oeNext;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      level_q <= '0;
    end else begin
      level_q <= flag_q & enable_q;
    end
  end
  assign channelIrq = level_q;

  irq_arbiter #(.N(N)) u_arb (
    .clk(clk),
    .sys_rst(sys_rst),
    .req(level_q),
    .prio(prioFlat),
    .sub(subFlat),
    .cpuIrq(cpuIrq),
    .vector(irqVector),
    .level(irqLevel)
  );

  // Read mux
  always_comb begin
    rdata = 32'h0000_0000;
    if (inChan) begin
      for (int i = 0; i < N; i++) begin
        if (chSel == 3'(i)) rdata = chWord[i];
      end
    end else begin
      case (word)
        OFS_PERIOD: rdata = {16'h0000, periodReg_q};
        OFS_PRESCALE: rdata = {16'h0000, prescale_q};
        OFS_FLAGS: rdata = {27'h0, flag_q};
        OFS_ENABLES: rdata = {27'h0, enable_q};
        OFS_PORT_OUT: rdata = {27'h0, portOut_q};
        OFS_PIN_DIR: rdata = {27'h0, pinDir_q};
        OFS_IRQ_STAT: rdata = {23'h0, cpuIrq, irqLevel, irqVector, 2'h0};
        default: rdata = 32'h0000_0000;
      endcase
    end
  end

  // Bus handshake: one wait cycle, answer on the second edge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ackPend_q <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else begin
      ackPend_q <= acceptNow;
      avs_waitrequest <= !acceptNow;
      if (avs_read && !ackPend_q) avs_readdata <= rdata;
    end
  end
endmodule // compare_pwm_channels

// ### verif/pwm_load_model.sv
// Load on the five compare pins, one pull-down on each.
// Assumes a pin is driven only while its enable is high.
`timescale 1ns/1ps
module pwm_load_model (
  input wire logic [4:0] pin,
  input wire logic [4:0] oe,
  output logic [4:0] level
);
  // Released pins fall to the pull-down level
  assign level = pin & oe;
endmodule // pwm_load_model

// ### verif/compare_pwm_channels_assertions.sv
// Port checks for the compare PWM block.
// Assumes binding to compare_pwm_channels.
`timescale 1ns/1ps
module compare_pwm_channels_assertions (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [4:0] compare_output_pin_oe,
  input wire logic [4:0] channelIrq,
  input wire logic cpuIrq,
  input wire logic [2:0] irqVector,
  input wire logic [2:0] irqLevel
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  rst_quiet_a: assert property (disable iff (1'b0) $fell(sys_rst) |->
    avs_waitrequest && compare_output_pin_oe == 5'h00 && !cpuIrq) else $error("not quiet after reset");
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("waitrequest low too long");
  bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("no bus answer");
  wait_cause_a: assert property ($fell(avs_waitrequest) |-> $past(avs_read || avs_write))
    else $error("answer without request");
  rdata_hold_a: assert property (!$past(avs_read) |-> $stable(avs_readdata)) else $error("readdata moved");
  irq_vec_a: assert property (cpuIrq |-> irqVector <= 3'h4 && irqLevel != 3'h0)
    else $error("bad vector or level");
  irq_src_a: assert property (cpuIrq |-> (channelIrq | $past(channelIrq)) != 5'h00)
    else $error("irq without source");
  irq_none_a: assert property (channelIrq == 5'h00 ##1 channelIrq == 5'h00 |-> !cpuIrq)
    else $error("irq stays without source");
endmodule // compare_pwm_channels_assertions
bind compare_pwm_channels compare_pwm_channels_assertions i_compare_pwm_channels_assertions (.clk(clk),
  .sys_rst(sys_rst), .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .compare_output_pin_oe(compare_output_pin_oe),
  .channelIrq(channelIrq), .cpuIrq(cpuIrq), .irqVector(irqVector), .irqLevel(irqLevel));

// ### verif/compare_pwm_channels_tb.sv
// Self-checking bench for the compare PWM block.
// Assumes the load model and bound checker are compiled.
`timescale 1ns/1ps
module compare_pwm_channels_tb;
  import pwm_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic faultA_n = 1'b1;
  logic faultB_n = 1'b1;
  logic [4:0] pin, oe, chIrq, level;
  logic cpuIrq;
  logic [2:0] irqVector, irqLevel;
  logic [31:0] expQ[$];
  logic [15:0] duties[4] = '{16'h0, 16'h3, 16'h7, 16'h8};
  logic [4:0] pr0[5] = '{5'h0C, 5'h0C, 5'h14, 5'h17, 5'h00};
  logic [4:0] pr1[5] = '{5'h0C, 5'h14, 5'h17, 5'h14, 5'h0C};
  logic [2:0] ev[5] = '{3'h0, 3'h1, 3'h1, 3'h0, 3'h1};
  logic [15:0] d;
  int errors = 0;
  int samples_checked = 0;
  int seed;
  int hi;
  always #5 clk = ~clk;
  compare_pwm_channels i_compare_pwm_channels (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .fault_input_a_n(faultA_n),
    .fault_input_b_n(faultB_n), .compare_output_pin(pin), .compare_output_pin_oe(oe), .channelIrq(chIrq),
    .cpuIrq(cpuIrq), .irqVector(irqVector), .irqLevel(irqLevel));
  pwm_load_model i_pwm_load_model (.pin(pin), .oe(oe), .level(level));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bus(input logic w, input logic [5:0] a, input logic [15:0] v);
    @(posedge clk);
    avs_address <= {a, 2'b00};
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {16'h0000, v};
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    expQ.push_back(e);
    bus(1'b0, a, 16'h0000);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  function automatic logic [5:0] ca(input int c, input logic [1:0] k);
    return OFS_CH_BASE + CH_STRIDE * 6'(c) + {4'h0, k};
  endfunction
  // Read results are matched in issue order
  always @(posedge clk) begin
    if (avs_read && !avs_waitrequest) begin
      chk("readdata", expQ.pop_front(), avs_readdata);
    end
  end
  task automatic stop_test;
    $display("checked %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    stop_test();
  end
  initial begin
    seed = $urandom(90780);
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    rd(OFS_PERIOD, 32'h0);
    rd(OFS_PIN_DIR, {27'h0, RESET_DIR});
    rd(ca(0, CH_CTRL), 32'h0);
    rd(6'h07, 32'h0);
    avs_byteenable <= 4'h0;
    bus(1'b1, OFS_PERIOD, 16'h0055);
    avs_byteenable <= 4'hF;
    rd(OFS_PERIOD, 32'h0);
    $display("test reset done");
    bus(1'b1, ca(0, CH_CTRL), 16'h0000);
    bus(1'b1, ca(0, CH_ACTIVE), 16'h0003);
    bus(1'b1, OFS_PERIOD, 16'h0007);
    bus(1'b1, ca(0, CH_CTRL), 16'h0006);
    bus(1'b1, ca(0, CH_CTRL), 16'h8006);
    for (int p = 0; p < 2; p++) begin
      bus(1'b1, OFS_PRESCALE, 16'(p));
      for (int i = 0; i < 5; i++) begin
        d = (i < 4) ? duties[i] : 16'($urandom % 9);
        bus(1'b1, ca(0, CH_BUFFER), d);
        bus(1'b1, ca(0, CH_ACTIVE), 16'h00AA);
        tick(20 * (p + 1));
        hi = 0;
        repeat (16 * (p + 1)) begin
          @(posedge clk);
          if (level[0] === 1'b1) hi++;
        end
        chk("high count", 2 * (p + 1) * ((d > 16'h0007) ? 8 : int'(d)), hi);
        rd(ca(0, CH_ACTIVE), {16'h0, d});
      end
    end
    $display("test pwm done");
    bus(1'b1, OFS_PIN_DIR, 16'h001D);
    bus(1'b1, OFS_PORT_OUT, 16'h0002);
    tick(3);
    chk("oe", 32'h3, {27'h0, oe});
    chk("pin1", 32'h1, {31'h0, pin[1]});
    $display("test pins done");
    bus(1'b1, OFS_ENABLES, 16'h0000);
    bus(1'b1, ca(1, CH_CTRL), 16'h8006);
    tick(20);
    bus(1'b1, ca(0, CH_CTRL), 16'h0000);
    bus(1'b1, ca(1, CH_CTRL), 16'h0000);
    rd(OFS_FLAGS, 32'h3);
    rd(OFS_IRQ_STAT, 32'h0);
    bus(1'b1, OFS_ENABLES, 16'h0003);
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, ca(0, CH_PRIO), {11'h0, pr0[i]});
      bus(1'b1, ca(1, CH_PRIO), {11'h0, pr1[i]});
      tick(3);
      chk("cpuIrq", 32'h1, {31'h0, cpuIrq});
      chk("irq vector", {29'h0, ev[i]}, {29'h0, irqVector});
      chk("irq level", {29'h0, (ev[i] != 3'h0) ? pr1[i][4:2] : pr0[i][4:2]}, {29'h0, irqLevel});
      rd(OFS_IRQ_STAT, {23'h0, 1'b1, (ev[i] != 3'h0) ? pr1[i][4:2] : pr0[i][4:2], ev[i], 2'b00});
    end
    chk("chIrq", 32'h3, {27'h0, chIrq});
    bus(1'b1, ca(0, CH_PRIO), 16'h000C);
    bus(1'b1, OFS_FLAGS, 16'h0001);
    tick(3);
    rd(OFS_IRQ_STAT, 32'h164);
    bus(1'b1, ca(1, CH_PRIO), 16'h0000);
    tick(3);
    chk("cpuIrq", 32'h0, {31'h0, cpuIrq});
    rd(OFS_IRQ_STAT, 32'h0);
    chk("chIrq", 32'h2, {27'h0, chIrq});
    $display("test irq done");
    bus(1'b1, ca(0, CH_CTRL), 16'h8007);
    bus(1'b1, ca(4, CH_CTRL), 16'h8007);
    tick(4);
    @(posedge clk);
    faultB_n <= 1'b0;
    tick(3);
    chk("oe", 32'h3, {27'h0, oe});
    chk("level4", 32'h0, {31'h0, level[4]});
    @(posedge clk);
    faultB_n <= 1'b1;
    tick(3);
    chk("oe", 32'h3, {27'h0, oe});
    rd(ca(4, CH_CTRL), 32'h8017);
    bus(1'b1, ca(4, CH_CTRL), 16'h8007);
    tick(3);
    chk("oe", 32'h13, {27'h0, oe});
    @(posedge clk);
    faultA_n <= 1'b0;
    tick(3);
    chk("oe", 32'h12, {27'h0, oe});
    $display("test fault done");
    stop_test();
  end
endmodule // compare_pwm_channels_tb
